// ==== shared/pad_pkg.sv ====
`default_nettype none

package pad_pkg;

    // management register addresses
    localparam logic [4:0] PAD_ADDR_DIAG = 5'h12;
    localparam logic [4:0] PAD_ADDR_XCVR = 5'h13;

    // reset values
    localparam logic [15:0] PAD_DIAG_RESET = 16'h0000;
    localparam logic [15:0] PAD_XCVR_RESET = 16'h4000;
    localparam logic [15:0] PAD_UNMAPPED_DATA = 16'h0000;

    // diagnostic register field positions
    localparam int PAD_DIAG_FAIL_BIT = 12;
    localparam int PAD_DIAG_RESOLVED_FULL_DUPLEX_BIT = 11;
    localparam int PAD_DIAG_RATE_BIT = 10;
    localparam int PAD_DIAG_SDET_BIT = 9;
    localparam int PAD_DIAG_LOCK_BIT = 8;

    // transceiver control: gain field in the upper two bits, rest reserved
    localparam int PAD_GAIN_LSB = 14;
    localparam int PAD_GAIN_W = 2;
    localparam logic [PAD_GAIN_W-1:0] PAD_GAIN_RESET = PAD_XCVR_RESET[15:14];

    // synchroniser depth for analog status levels
    localparam int PAD_SYNC_STAGES = 2;

    // one management access, as presented by the management interface logic
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pad_mgmt_req_s;

    // auto-negotiation outcome from the negotiation engine (same clock)
    typedef struct packed {
        logic done;
        logic failed;
        logic full_duplex;
        logic speed_100;
    } pad_an_result_s;

endpackage

`default_nettype wire

// ==== verilog/pad_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module pad_sync
#(
    parameter int WIDTH = 2
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import pad_pkg::*;

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    // stage1 feeds stage2 only
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1 <= '0;
            stage2 <= '0;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;

endmodule

`default_nettype wire

// ==== verilog/pad_regs.sv ====
`timescale 1ns/100ps
`default_nettype none

module pad_regs
(
    input wire logic clk,
    input wire logic reset_n,
    input wire pad_pkg::pad_mgmt_req_s mgmt_req,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire pad_pkg::pad_an_result_s an_result,
    input wire logic rx_signal_detect_pin,
    input wire logic rx_pll_lock_pin,
    output logic [1:0] tx_gain
);
    import pad_pkg::*;

    logic autoneg_failed_flag;
    logic resolved_full_duplex;
    logic resolved_speed_100;
    logic receive_signal_detect;
    logic rx_pll_locked;
    logic [PAD_GAIN_W-1:0] gain;
    logic [15:0] rdata;
    logic rvalid;

    logic next_autoneg_failed_flag;
    logic next_resolved_full_duplex;
    logic next_resolved_speed_100;
    logic [PAD_GAIN_W-1:0] next_gain;
    logic [15:0] next_rdata;
    logic next_rvalid;

    logic [1:0] analog_sync;
    logic [15:0] diag_value;
    logic [15:0] xcvr_value;
    logic diag_read;

    // signal detect and pll lock come from the analog front end
    pad_sync #(.WIDTH(2)) u_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({rx_signal_detect_pin, rx_pll_lock_pin}),
        .sync_out(analog_sync)
    );

    assign receive_signal_detect = analog_sync[1];
    assign rx_pll_locked = analog_sync[0];

    always_comb
    begin
        diag_value = PAD_DIAG_RESET;
        diag_value[PAD_DIAG_FAIL_BIT] = autoneg_failed_flag;
        diag_value[PAD_DIAG_RESOLVED_FULL_DUPLEX_BIT] = resolved_full_duplex;
        diag_value[PAD_DIAG_RATE_BIT] = resolved_speed_100;
        diag_value[PAD_DIAG_SDET_BIT] = receive_signal_detect;
        diag_value[PAD_DIAG_LOCK_BIT] = rx_pll_locked;
        xcvr_value = '0;
        xcvr_value[PAD_GAIN_LSB +: PAD_GAIN_W] = gain;
    end

    assign diag_read = mgmt_req.rd && (mgmt_req.addr == PAD_ADDR_DIAG);

    // negotiation outcome state
    always_comb
    begin
        next_autoneg_failed_flag = autoneg_failed_flag;
        next_resolved_full_duplex = resolved_full_duplex;
        next_resolved_speed_100 = resolved_speed_100;
        if (diag_read)
        begin
            next_autoneg_failed_flag = 1'b0;
        end
        // a failure in the clearing cycle must not be lost
        if (an_result.done && an_result.failed)
        begin
            next_autoneg_failed_flag = 1'b1;
        end
        // no common mode means nothing resolved; keep last good result
        if (an_result.done && !an_result.failed)
        begin
            next_resolved_full_duplex = an_result.full_duplex;
            next_resolved_speed_100 = an_result.speed_100;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            autoneg_failed_flag <= PAD_DIAG_RESET[PAD_DIAG_FAIL_BIT];
            resolved_full_duplex <= PAD_DIAG_RESET[PAD_DIAG_RESOLVED_FULL_DUPLEX_BIT];
            resolved_speed_100 <= PAD_DIAG_RESET[PAD_DIAG_RATE_BIT];
        end
        else
        begin
            autoneg_failed_flag <= next_autoneg_failed_flag;
            resolved_full_duplex <= next_resolved_full_duplex;
            resolved_speed_100 <= next_resolved_speed_100;
        end
    end

    // management access: write and read decode
    always_comb
    begin
        next_gain = gain;
        next_rdata = rdata;
        next_rvalid = 1'b0;
        // reserved bits of 0x13 drop writes; 0x12 is read only
        if (mgmt_req.wr && (mgmt_req.addr == PAD_ADDR_XCVR))
        begin
            next_gain = mgmt_req.wdata[PAD_GAIN_LSB +: PAD_GAIN_W];
        end
        if (mgmt_req.rd)
        begin
            next_rvalid = 1'b1;
            unique case (mgmt_req.addr)
                PAD_ADDR_DIAG: next_rdata = diag_value;
                PAD_ADDR_XCVR: next_rdata = xcvr_value;
                default: next_rdata = PAD_UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gain <= PAD_GAIN_RESET;
            rdata <= '0;
            rvalid <= 1'b0;
        end
        else
        begin
            gain <= next_gain;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign mgmt_rdata = rdata;
    assign mgmt_rvalid = rvalid;
    assign tx_gain = gain;

    // assertions

    sequence s_diag_read;
        mgmt_req.rd && mgmt_req.addr == PAD_ADDR_DIAG;
    endsequence

    sequence s_fail_event;
        an_result.done && an_result.failed;
    endsequence

    a_fail_sets: assert property (@(posedge clk) disable iff (!reset_n)
        s_fail_event |=> autoneg_failed_flag)
        else $error("failure flag not set after failed negotiation");

    a_fail_holds: assert property (@(posedge clk) disable iff (!reset_n)
        autoneg_failed_flag && !diag_read |=> autoneg_failed_flag)
        else $error("failure flag dropped without a read");

    a_fail_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
        s_diag_read ##0 !(an_result.done && an_result.failed) |=> !autoneg_failed_flag)
        else $error("failure flag not cleared by read");

    a_diag_readback: assert property (@(posedge clk) disable iff (!reset_n)
        s_diag_read |=> mgmt_rvalid && mgmt_rdata == $past(diag_value)
            && mgmt_rdata[15:13] == 3'h0 && mgmt_rdata[7:0] == 8'h00)
        else $error("diagnostic read data wrong");

    a_duplex_resolve: assert property (@(posedge clk) disable iff (!reset_n)
        an_result.done && !an_result.failed
            |=> resolved_full_duplex == $past(an_result.full_duplex))
        else $error("duplex result not captured");

    // checked at the diagnostic word; readback of that word is a_diag_readback
    a_rate_resolve: assert property (@(posedge clk) disable iff (!reset_n)
        an_result.done && !an_result.failed
            |=> diag_value[PAD_DIAG_RATE_BIT] == $past(an_result.speed_100))
        else $error("rate bit does not show resolved speed");

    a_lock_follows: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(rx_pll_lock_pin) ##1 rx_pll_lock_pin [*2]
            |-> diag_value[PAD_DIAG_LOCK_BIT])
        else $error("pll lock bit late");

    a_detect_follows: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(rx_signal_detect_pin) ##1 !rx_signal_detect_pin [*2]
            |-> !diag_value[PAD_DIAG_SDET_BIT])
        else $error("signal detect bit late");

    // manager leaves one idle cycle between accesses, so the read comes two later
    a_gain_write: assert property (@(posedge clk) disable iff (!reset_n)
        mgmt_req.wr && mgmt_req.addr == PAD_ADDR_XCVR ##1 !mgmt_req.wr ##1 mgmt_req.rd
            && mgmt_req.addr == PAD_ADDR_XCVR
            |=> mgmt_rdata == {$past(mgmt_req.wdata[15:14], 3), 14'h0000})
        else $error("transceiver control readback wrong");

endmodule

`default_nettype wire

// ==== verif/pad_mgmt_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module pad_mgmt_model
(
    input wire logic clk,
    output var pad_pkg::pad_mgmt_req_s mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid
);
    initial mgmt_req = '0;

    // one-cycle strobe just after an edge; answer taken one edge later
    task automatic access(input logic rd, input logic wr, input logic [4:0] addr,
        input logic [15:0] wdata, output logic [15:0] rdata, output logic ok);
        @(posedge clk);
        #1;
        mgmt_req = '{rd: rd, wr: wr, addr: addr, wdata: wdata};
        @(posedge clk);
        #1;
        // idle fields toggled so a stale value is never mistaken for a request
        mgmt_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        ok = (mgmt_rvalid === rd);
        rdata = mgmt_rdata;
    endtask
endmodule

`default_nettype wire

// ==== verif/phy_autoneg_diag_regs_test.sv ====
`timescale 1ns/100ps
`default_nettype none

module phy_autoneg_diag_regs_test;
    import pad_pkg::*;
    logic clk;
    logic reset_n;
    pad_mgmt_req_s mgmt_req;
    logic [15:0] mgmt_rdata;
    logic mgmt_rvalid;
    pad_an_result_s an_result;
    logic rx_signal_detect_pin;
    logic rx_pll_lock_pin;
    logic [1:0] tx_gain;
    int error_cnt = 0;
    int check_count = 0;
    logic m_fail, m_resolved_full_duplex, m_rate;
    logic [1:0] m_gain;
    logic [15:0] rd_data;
    logic [15:0] w;
    logic [2:0] v;
    logic ok;

    pad_regs dut (.clk(clk), .reset_n(reset_n), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .an_result(an_result),
        .rx_signal_detect_pin(rx_signal_detect_pin), .rx_pll_lock_pin(rx_pll_lock_pin),
        .tx_gain(tx_gain));
    pad_mgmt_model mgmt (.clk(clk), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic access_chk(input logic rd, input logic [4:0] a, input logic [15:0] d);
        mgmt.access(rd, ~rd, a, d, rd_data, ok);
        check({15'h0000, ok}, 16'h0001);
    endtask

    task automatic read_chk(input logic [4:0] a, input logic [15:0] exp);
        access_chk(1'b1, a, 16'h0000);
        check(rd_data, exp);
    endtask

    // expectation built before the read; the read then clears the failure flag
    task automatic poll_diag();
        read_chk(PAD_ADDR_DIAG, {3'b000, m_fail, m_resolved_full_duplex, m_rate, rx_signal_detect_pin,
            rx_pll_lock_pin, 8'h00});
        m_fail = 1'b0;
    endtask

    task automatic negotiate(input logic f, input logic fd, input logic sp);
        @(posedge clk);
        #1;
        an_result = '{done: 1'b1, failed: f, full_duplex: fd, speed_100: sp};
        @(posedge clk);
        #1;
        an_result = '{done: 1'b0, failed: ~f, full_duplex: ~fd, speed_100: ~sp};
        m_fail = m_fail | f;
        m_resolved_full_duplex = f ? m_resolved_full_duplex : fd;
        m_rate = f ? m_rate : sp;
    endtask

    initial
    begin
        #400000;
        error_cnt++;
        complete_run();
    end

    initial
    begin
        void'($urandom(52));
        reset_n = 1'b0;
        an_result = '0;
        {rx_signal_detect_pin, rx_pll_lock_pin} = 2'b00;
        {m_fail, m_resolved_full_duplex, m_rate} = 3'b000;
        repeat (20) @(posedge clk);
        #1;
        reset_n = 1'b1;
        read_chk(PAD_ADDR_DIAG, PAD_DIAG_RESET);
        read_chk(PAD_ADDR_XCVR, PAD_XCVR_RESET);
        check({14'h0000, tx_gain}, {14'h0000, PAD_GAIN_RESET});
        // failed result must not disturb duplex or rate; flag survives until read
        negotiate(1'b1, 1'b1, 1'b1);
        repeat (3) @(posedge clk);
        poll_diag();
        poll_diag();
        repeat (24)
        begin
            {rx_signal_detect_pin, rx_pll_lock_pin} = 2'($urandom);
            v = 3'($urandom);
            negotiate(v[2], v[1], v[0]);
            w = 16'($urandom);
            access_chk(1'b0, PAD_ADDR_XCVR, w);
            m_gain = w[15:14];
            check({14'h0000, tx_gain}, {14'h0000, m_gain});
            read_chk(PAD_ADDR_XCVR, {m_gain, 14'h0000});
            access_chk(1'b0, PAD_ADDR_DIAG, w);
            read_chk(5'h14, PAD_UNMAPPED_DATA);
            poll_diag();
        end
        complete_run();
    end
endmodule

`default_nettype wire
